// ==== hw/accessory_event_control.sv ====
// Key classification, power save, switch setup, removal_flag, resets and interrupt flags
// Operation
// - Ignore key activity under 20 ms, then time.
// - Press below short minimum gives no flag.
// - Short press sets short flag, keeps code.
// - Short press interrupts at release, read clears.
// - Long hold sets held flag, keeps code.
// - Release after long hold sets release flag.
// - Auto mode: 10 s audio silence with rc_accessory attached enters power save.
// - Auto mode: audio activity returns to active.
// - Manual mode: host request bit selects power save.
// - Key monitoring continues during power save.
// - UART test cables close UART, power off.
// - USB test cables close USB, power on.
// - USB host: power on, current select released.
// - Chargers: power on, host selects current.
// - Carkit chargers: power on, host selects current.
// - Supply drop or ID removal starts removal_flag.
// - Removal_flag sets removal flag, ends clearing active.
// - After removal_flag, supply or ID restarts identification.
// - Both bus lines held low cause full reset.
// - Filter short IO supply drops, reset on long.
// - Software reset bit resets all, self-clears.
// - Unmasked set flags hold interrupt low.
// - Flags ignore writes; read clears them all.
// - Short minimum 100 ms plus 100 ms per code.
// - Long minimum 300 ms plus 100 ms per code.
`timescale 1ns/1ns
module accessory_event_control
  import accessory_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES   = DEBOUNCE_CYC,
  parameter int unsigned PRESS_STEP_CYCLES = PRESS_STEP_CYC,
  parameter int unsigned IDLE_CYCLES       = IDLE_CYC
) (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire reg_req_s     reg_req,
  output logic [7:0]        reg_rdata,
  input  wire logic         key_pin,
  input  wire logic [4:0]   adc_code,
  input  wire logic         adc_update,
  input  wire logic         adc_busy,
  input  wire logic         ident_done,
  input  wire logic         rc_accessory,
  input  wire supply_type_s supply_type,
  input  wire logic         vbus_det_pin,
  input  wire logic         id_present_pin,
  input  wire logic         left_audio_in,
  input  wire logic         right_audio_in,
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  input  wire logic         host_io_supply,
  input  wire logic         over_voltage_ev,
  input  wire logic         over_temp_ev,
  input  wire logic         guard_off_ev,
  output logic              ident_start,
  output logic              uart_close,
  output logic              usb_close,
  output logic [2:0]        dp_dm_route,
  output logic [1:0]        vbus_route,
  output logic              power_switch_on,
  output logic              power_save,
  output logic              standby,
  output logic              sys_reset,
  input  wire logic         int_in,
  output logic              int_out,
  output logic              int_oe_n,
  input  wire logic         charge_current_select_in,
  output logic              charge_current_select_out,
  output logic              charge_current_select_oe_n
);
  logic [6:0]  pins_s;
  logic        key_s;
  logic        vbus_s;
  logic        id_s;
  logic        audio_l_s;
  logic        audio_r_s;
  logic        scl_s;
  logic        sda_s;
  logic        io_s;
  logic        bus_rst;
  logic        io_rst;
  logic [7:0]  int_flags;
  logic [7:0]  int_mask;
  logic [4:0]  adc_result;
  logic [7:0]  timing_set;
  logic [7:0]  sw_ctrl1;
  logic [7:0]  sw_ctrl2;
  logic [7:0]  ctrl;
  logic [7:0]  time_delay;
  logic [7:0]  dev_mode;
  key_state_e  key_state;
  key_state_e  next_key_state;
  logic [31:0] press_cnt;
  link_state_e link_state;
  link_state_e next_link_state;
  logic [31:0] settle_cnt;
  logic [31:0] idle_cnt;
  logic        auto_save;
  logic        vbus_d;
  logic        id_d;

  sync_two_ff #(.WIDTH(7)) u_sync (
    .clk   (core_clk),
    .rst_n (arst_n),
    .din   ({key_pin, vbus_det_pin, id_present_pin, left_audio_in, right_audio_in,
             scl_in, sda_in}),
    .dout  (pins_s)
  );
  sync_two_ff #(.WIDTH(1)) u_sync_io (
    .clk   (core_clk),
    .rst_n (arst_n),
    .din   (host_io_supply),
    .dout  (io_s)
  );
  assign {key_s, vbus_s, id_s, audio_l_s, audio_r_s, scl_s, sda_s} = pins_s;

  glitch_filter #(.COUNT(BUS_RST_CYC)) u_bus_rst (
    .clk   (core_clk),
    .rst_n (arst_n),
    .din   (!scl_s && !sda_s),
    .dout  (bus_rst)
  );
  // Short drops never reach the count, so only long ones reset the block
  glitch_filter #(.COUNT(IO_DGT_CYC)) u_io_rst (
    .clk   (core_clk),
    .rst_n (arst_n),
    .din   (!io_s),
    .dout  (io_rst)
  );

  // Register decode
  wire wr_mask   = reg_req.wr && reg_req.addr == ADDR_MASK;
  wire wr_timing = reg_req.wr && reg_req.addr == ADDR_TIMING;
  wire wr_sw1    = reg_req.wr && reg_req.addr == ADDR_SW1;
  wire wr_sw2    = reg_req.wr && reg_req.addr == ADDR_SW2;
  wire wr_ctrl   = reg_req.wr && reg_req.addr == ADDR_CTRL;
  wire wr_tdelay = reg_req.wr && reg_req.addr == ADDR_TDELAY;
  wire wr_mode   = reg_req.wr && reg_req.addr == ADDR_MODE;
  wire rd_int    = reg_req.rd && reg_req.addr == ADDR_INT;
  wire soft_req  = wr_ctrl && reg_req.wdata[CTRL_SOFT_RST_BIT];
  wire rst_req   = bus_rst || io_rst || soft_req;

  // Registers and state machines return to reset values two cycles after any reset source
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      sys_reset <= 1'b0;
    else
      sys_reset <= rst_req;
  end

  // Press thresholds, codes past the table clamp to the top entry
  wire [3:0]  short_code = timing_set[7:4] > SHORT_MAX_CODE ? SHORT_MAX_CODE : timing_set[7:4];
  wire [3:0]  long_code  = timing_set[3:0] > LONG_MAX_CODE ? LONG_MAX_CODE : timing_set[3:0];
  wire [31:0] short_steps = 32'(short_code) + 32'(SHORT_BASE_STEPS);
  wire [31:0] long_steps  = 32'(long_code) + 32'(LONG_BASE_STEPS);
  wire [31:0] short_thr   = 32'(short_steps * PRESS_STEP_CYCLES);
  wire [31:0] long_thr    = 32'(long_steps * PRESS_STEP_CYCLES);
  wire deb_done  = press_cnt >= 32'(DEBOUNCE_CYCLES - 1);
  wire key_short = key_state == KEY_TIMING && !key_s && press_cnt >= short_thr;
  wire key_held  = key_state == KEY_TIMING && key_s && press_cnt >= long_thr;
  wire key_rel   = key_state == KEY_HELD && !key_s;

  // Key timing runs in every power mode
  always_comb
  begin
    next_key_state = key_state;
    case (key_state)
      KEY_IDLE:     if (key_s) next_key_state = KEY_DEBOUNCE;
      KEY_DEBOUNCE: if (!key_s) next_key_state = KEY_IDLE;
                    else if (deb_done) next_key_state = KEY_TIMING;
      KEY_TIMING:   if (!key_s) next_key_state = KEY_IDLE;
                    else if (key_held) next_key_state = KEY_HELD;
      KEY_HELD:     if (!key_s) next_key_state = KEY_IDLE;
      default:      next_key_state = KEY_IDLE;
    endcase
  end

  wire key_start = key_state == KEY_DEBOUNCE && next_key_state == KEY_TIMING;
  wire [31:0] next_press_cnt = (key_state != next_key_state || key_state == KEY_IDLE) ? 32'h0 :
                               (&press_cnt) ? press_cnt : press_cnt + 32'h1;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      key_state <= KEY_IDLE;
      press_cnt <= '0;
    end
    else if (sys_reset)
    begin
      key_state <= KEY_IDLE;
      press_cnt <= '0;
    end
    else
    begin
      key_state <= next_key_state;
      press_cnt <= next_press_cnt;
    end
  end

  // Key code is frozen from debounce pass until the key returns to idle
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      adc_result <= RST_ADC;
    else if (sys_reset)
      adc_result <= RST_ADC;
    else if (key_start || (adc_update && key_state == KEY_IDLE))
      adc_result <= adc_code;
  end

  // Insertion_flag and removal_flag sequencing
  wire removal_flag_trig = (vbus_d && !vbus_s) || (id_d && !id_s);
  wire settle_done = settle_cnt >= 32'(REMOVAL_FLAG_SETTLE_CYC - 1);

  always_comb
  begin
    next_link_state = link_state;
    case (link_state)
      LINK_STANDBY:   if (ident_done) next_link_state = LINK_ATTACHED;
      LINK_ATTACHED:  if (removal_flag_trig) next_link_state = LINK_DETACHING;
      LINK_DETACHING: if (settle_done) next_link_state = LINK_STANDBY;
      default:        next_link_state = LINK_STANDBY;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link_state  <= LINK_STANDBY;
      settle_cnt  <= '0;
      vbus_d      <= 1'b0;
      id_d        <= 1'b0;
      ident_start <= 1'b0;
    end
    else if (sys_reset)
    begin
      link_state  <= LINK_STANDBY;
      settle_cnt  <= '0;
      vbus_d      <= vbus_s;
      id_d        <= id_s;
      ident_start <= 1'b0;
    end
    else
    begin
      link_state  <= next_link_state;
      settle_cnt  <= link_state == LINK_DETACHING ? settle_cnt + 32'h1 : 32'h0;
      vbus_d      <= vbus_s;
      id_d        <= id_s;
      ident_start <= link_state == LINK_STANDBY &&
                     ((vbus_s && !vbus_d) || (id_s && !id_d));
    end
  end

  wire attached = link_state == LINK_ATTACHED;
  wire removal_flag_end = link_state == LINK_DETACHING && settle_done;

  // Interrupt flags: a new event wins over the read clear of the same cycle
  wire [7:0] flag_set = {guard_off_ev, over_temp_ev, over_voltage_ev,
                         key_rel, key_held, key_short,
                         attached && removal_flag_trig,
                         link_state == LINK_STANDBY && ident_done};
  wire [7:0] next_flags = (rd_int ? 8'h00 : int_flags) | flag_set;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      int_flags <= 8'h00;
    else if (sys_reset)
      int_flags <= 8'h00;
    else
      int_flags <= next_flags;
  end

  assign int_out  = 1'b0;
  assign int_oe_n = !(|(int_flags & ~int_mask));

  // Software registers
  wire [7:0] next_mode_sw = wr_mode ? reg_req.wdata : dev_mode;
  wire [7:0] next_mode = attached ? (next_mode_sw | (8'h01 << MODE_ACTIVE_BIT)) :
                         removal_flag_end ? (next_mode_sw & ~(8'h01 << MODE_ACTIVE_BIT)) :
                         next_mode_sw;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      int_mask   <= 8'h00;
      timing_set <= 8'h00;
      sw_ctrl1   <= RST_SW1;
      sw_ctrl2   <= RST_SW2;
      ctrl       <= RST_CTRL;
      time_delay <= RST_TDELAY;
      dev_mode   <= RST_MODE;
    end
    else if (sys_reset)
    begin
      int_mask   <= 8'h00;
      timing_set <= 8'h00;
      sw_ctrl1   <= RST_SW1;
      sw_ctrl2   <= RST_SW2;
      ctrl       <= RST_CTRL;
      time_delay <= RST_TDELAY;
      dev_mode   <= RST_MODE;
    end
    else
    begin
      if (wr_mask)   int_mask   <= reg_req.wdata;
      if (wr_timing) timing_set <= reg_req.wdata;
      if (wr_sw1)    sw_ctrl1   <= reg_req.wdata;
      if (wr_sw2)    sw_ctrl2   <= reg_req.wdata;
      if (wr_ctrl)   ctrl       <= reg_req.wdata & ~(8'h01 << CTRL_SOFT_RST_BIT);
      if (wr_tdelay) time_delay <= reg_req.wdata;
      dev_mode <= next_mode;
    end
  end

  // Power save
  wire auto_en  = ctrl[CTRL_AUTO_LP_BIT];
  wire activity = audio_l_s || audio_r_s;
  wire idle_ok  = auto_en && attached && rc_accessory;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      idle_cnt  <= '0;
      auto_save <= 1'b0;
    end
    else if (sys_reset || !idle_ok || activity)
    begin
      idle_cnt  <= '0;
      auto_save <= 1'b0;
    end
    else if (idle_cnt < 32'(IDLE_CYCLES - 1))
      idle_cnt <= idle_cnt + 32'h1;
    else
      auto_save <= 1'b1;
  end

  assign power_save = auto_en ? auto_save : dev_mode[MODE_LP_BIT];
  assign standby    = !dev_mode[MODE_ACTIVE_BIT];

  // Switch and power switch setup
  wire test_uart = attached && (adc_result == ID_UART_T1 || adc_result == ID_UART_T2);
  wire test_usb  = attached && (adc_result == ID_USB_T1 || adc_result == ID_USB_T2);
  wire supply_on = attached && vbus_s && (supply_type.id_float || supply_type.dp_dm_short ||
                                          supply_type.usb_chg);
  wire next_power = test_usb ? 1'b1 : test_uart ? 1'b0 : supply_on;

  // Test cable routing owns the switches while the cable stays attached
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      uart_close      <= 1'b0;
      usb_close       <= 1'b0;
      power_switch_on <= 1'b0;
      dp_dm_route     <= 3'h0;
      vbus_route      <= 2'h1;
    end
    else
    begin
      uart_close      <= test_uart;
      usb_close       <= test_usb;
      power_switch_on <= next_power;
      dp_dm_route     <= (test_uart || test_usb) ? 3'h0 : sw_ctrl1[4:2];
      vbus_route      <= (test_uart || test_usb) ? 2'h0 : sw_ctrl1[1:0];
    end
  end

  // Current select stays released until software asks for the higher level
  assign charge_current_select_out  = 1'b0;
  assign charge_current_select_oe_n = !sw_ctrl2[SW2_CSEL_BIT];

  // Read path
  wire [7:0] status = {1'b0, power_switch_on, supply_type.usb_chg, supply_type.dp_dm_short,
                       supply_type.id_gnd, supply_type.id_float, vbus_s, adc_busy};
  wire [7:0] rd_mux = reg_req.addr == ADDR_INT    ? int_flags :
                      reg_req.addr == ADDR_MASK   ? int_mask :
                      reg_req.addr == ADDR_ADC    ? {3'h0, adc_result} :
                      reg_req.addr == ADDR_TIMING ? timing_set :
                      reg_req.addr == ADDR_SW1    ? sw_ctrl1 :
                      reg_req.addr == ADDR_SW2    ? sw_ctrl2 :
                      reg_req.addr == ADDR_STATUS ? status :
                      reg_req.addr == ADDR_CTRL   ? ctrl :
                      reg_req.addr == ADDR_TDELAY ? time_delay :
                      reg_req.addr == ADDR_MODE   ? dev_mode : 8'h00;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_req.rd ? rd_mux : 8'h00;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_debounce_drop: assert property (
    (key_state == KEY_DEBOUNCE && !key_s && !sys_reset) |=> key_state == KEY_IDLE)
    else $error("early key release not discarded");
  a_error_press: assert property (
    (key_state == KEY_TIMING && !key_s && press_cnt < short_thr) |-> !flag_set[FLAG_SHORT])
    else $error("error press raised a flag");
  a_short_flag: assert property (
    (key_short && !sys_reset) |=> int_flags[FLAG_SHORT] && key_state == KEY_IDLE)
    else $error("short press flag missing");
  a_held_flag: assert property (
    (key_held && !sys_reset) |=> int_flags[FLAG_HELD] && key_state == KEY_HELD)
    else $error("held flag missing");
  a_release_flag: assert property (
    (key_rel && !sys_reset) |=> int_flags[FLAG_HELD_REL] && adc_result == $past(adc_result))
    else $error("held release flag missing");
  a_int_unmasked: assert property (
    (|(flag_set & ~int_mask) && !sys_reset && !wr_mask) |=> !int_oe_n)
    else $error("unmasked flag did not pull interrupt");
  a_read_clear: assert property (
    (rd_int && flag_set == 8'h00 && !sys_reset) |=> int_flags == 8'h00 && int_oe_n)
    else $error("flag read did not clear");
  a_write_ignored: assert property (
    (reg_req.wr && reg_req.addr == ADDR_INT && !sys_reset)
      |=> int_flags == ($past(int_flags) | $past(flag_set)))
    else $error("flag register took a write");
  a_auto_wake: assert property (
    (auto_save && activity && !wr_ctrl) |=> !auto_save ##1 !auto_save || activity)
    else $error("activity did not leave power save");
  a_uart_cable: assert property (
    (test_uart && !sys_reset) |=> uart_close && !usb_close && !power_switch_on)
    else $error("uart test cable setup wrong");
  a_removal_flag_end: assert property (
    (removal_flag_end && !sys_reset) |=> !dev_mode[MODE_ACTIVE_BIT] && link_state == LINK_STANDBY)
    else $error("removal_flag did not end in standby");
  a_soft_reset: assert property (
    (soft_req && !sys_reset) |=> sys_reset ##1 (int_mask == 8'h00 && ctrl == RST_CTRL))
    else $error("software reset did not clear registers");

  c_short_press: cover property (key_short);
  c_held_release: cover property (key_state == KEY_HELD ##[1:8] key_rel);
  c_removal_flag: cover property (removal_flag_end);
  c_auto_save: cover property ($rose(auto_save));
endmodule

// ==== hw/accessory_pkg.sv ====
// Shared constants, states and carriers for the accessory event controller
package accessory_pkg;
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned DEBOUNCE_MS      = 20;
  localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned PRESS_STEP_MS    = 100;
  localparam int unsigned PRESS_STEP_CYC   = PRESS_STEP_MS * (CLK_HZ / 1000);
  localparam int unsigned SHORT_BASE_STEPS = 1;
  localparam int unsigned LONG_BASE_STEPS  = 3;
  localparam logic [3:0]  SHORT_MAX_CODE   = 4'h9;
  localparam logic [3:0]  LONG_MAX_CODE    = 4'hc;
  localparam int unsigned IDLE_S           = 10;
  localparam int unsigned IDLE_CYC         = IDLE_S * CLK_HZ;
  localparam int unsigned BUS_RST_US       = 20;
  localparam int unsigned BUS_RST_CYC      = BUS_RST_US * (CLK_HZ / 1_000_000);
  localparam int unsigned IO_DGT_US        = 100;
  localparam int unsigned IO_DGT_CYC       = IO_DGT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned REMOVAL_FLAG_SETTLE_CYC = 16;

  localparam logic [7:0] ADDR_INT    = 8'h83;
  localparam logic [7:0] ADDR_MASK   = 8'h85;
  localparam logic [7:0] ADDR_ADC    = 8'h87;
  localparam logic [7:0] ADDR_TIMING = 8'h88;
  localparam logic [7:0] ADDR_SW1    = 8'h93;
  localparam logic [7:0] ADDR_SW2    = 8'h94;
  localparam logic [7:0] ADDR_STATUS = 8'ha0;
  localparam logic [7:0] ADDR_CTRL   = 8'ha1;
  localparam logic [7:0] ADDR_TDELAY = 8'ha2;
  localparam logic [7:0] ADDR_MODE   = 8'ha3;

  localparam logic [4:0] RST_ADC    = 5'h1f;
  localparam logic [7:0] RST_SW1    = 8'h01;
  localparam logic [7:0] RST_SW2    = 8'h04;
  localparam logic [7:0] RST_CTRL   = 8'h60;
  localparam logic [7:0] RST_TDELAY = 8'h94;
  localparam logic [7:0] RST_MODE   = 8'h01;

  localparam int FLAG_INSERT   = 0;
  localparam int FLAG_REMOVE   = 1;
  localparam int FLAG_SHORT    = 2;
  localparam int FLAG_HELD     = 3;
  localparam int FLAG_HELD_REL = 4;
  localparam int FLAG_OVER_V   = 5;
  localparam int FLAG_OVER_T   = 6;
  localparam int FLAG_GUARD_OFF = 7;
  localparam int CTRL_AUTO_LP_BIT  = 5;
  localparam int CTRL_SOFT_RST_BIT = 2;
  localparam int MODE_LP_BIT       = 2;
  localparam int MODE_ACTIVE_BIT   = 1;
  localparam int SW2_CSEL_BIT      = 4;

  localparam logic [4:0] ID_UART_T1 = 5'h0e;
  localparam logic [4:0] ID_UART_T2 = 5'h0f;
  localparam logic [4:0] ID_USB_T1  = 5'h10;
  localparam logic [4:0] ID_USB_T2  = 5'h11;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  typedef struct packed {
    logic usb_chg;
    logic dp_dm_short;
    logic id_gnd;
    logic id_float;
  } supply_type_s;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00, KEY_DEBOUNCE = 2'b01, KEY_TIMING = 2'b10, KEY_HELD = 2'b11
  } key_state_e;

  typedef enum logic [1:0] {
    LINK_STANDBY = 2'b00, LINK_ATTACHED = 2'b01, LINK_DETACHING = 2'b10
  } link_state_e;
endpackage

// ==== hw/sync_two_ff.sv ====
// Two-flop synchroniser for levels from outside the core clock domain
`timescale 1ns/1ns
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage <= '0;
      dout  <= '0;
    end
    else
    begin
      stage <= din;
      dout  <= stage;
    end
  end
endmodule

// ==== hw/glitch_filter.sv ====
// Level qualifier: output rises only after input stays high COUNT cycles
`timescale 1ns/1ns
module glitch_filter #(
  parameter int unsigned COUNT = 16
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  logic [31:0] cnt;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt  <= '0;
      dout <= 1'b0;
    end
    else if (!din)
    begin
      cnt  <= '0;
      dout <= 1'b0;
    end
    else if (cnt < COUNT - 1)
      cnt <= cnt + 32'h1;
    else
      dout <= 1'b1;
  end
endmodule

// ==== verification/host_line_model.sv ====
// Host side of the open-drain interrupt and charge-current lines, both with pull-ups
`timescale 1ns/1ns
module host_line_model (
  input  wire logic int_out,
  input  wire logic int_oe_n,
  input  wire logic csel_out,
  input  wire logic csel_oe_n,
  output logic      int_line,
  output logic      csel_line
);
  // A released line floats up to the host supply, never to the last driven value
  assign int_line  = int_oe_n ? 1'b1 : int_out;
  assign csel_line = csel_oe_n ? 1'b1 : csel_out;
endmodule

// ==== verification/accessory_event_control_tb.sv ====
// Self-checking bench for the accessory event controller
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module accessory_event_control_tb;
  import accessory_pkg::*;
  typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] val;} row_t;
  logic core_clk = 0, arst_n = 0, key_pin = 0, adc_update = 0, ident_done = 0;
  logic rc_accessory = 0, vbus_det_pin = 1, id_present_pin = 1, left_audio_in = 0;
  logic right_audio_in = 0, scl_in = 1, sda_in = 1, host_io_supply = 1;
  logic [4:0] adc_code = 5'h1f;
  reg_req_s   reg_req = '0;
  logic [7:0] reg_rdata, d;
  logic [2:0] dp_dm_route;
  logic [1:0] vbus_route;
  logic       uart_close, usb_close, power_switch_on, power_save, standby, int_line;
  logic       int_out, int_oe_n, csel_out, csel_oe_n, csel_line;
  int         mismatches = 0, comparisons = 0, cyc = 0;
  logic       ident_start, sys_reset;
  logic [2:0] ev = 3'h0;
  supply_type_s sup = '0;
  row_t       rows[12] = '{'{0, 8'h93, 8'h01}, '{0, 8'h94, 8'h04}, '{0, 8'ha1, 8'h60},
    '{0, 8'h87, 8'h1f}, '{0, 8'h83, 8'h00}, '{0, 8'h00, 8'h00}, '{1, 8'h83, 8'hff},
    '{0, 8'h83, 8'h00}, '{1, 8'h85, 8'hff}, '{0, 8'h85, 8'hff}, '{1, 8'h85, 8'h00},
    '{0, 8'ha3, 8'h01}};
  always #25 core_clk = ~core_clk;
  accessory_event_control #(.DEBOUNCE_CYCLES(8), .PRESS_STEP_CYCLES(40), .IDLE_CYCLES(100))
  i_dut (.core_clk(core_clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .key_pin(key_pin), .adc_code(adc_code), .adc_update(adc_update), .adc_busy(1'b0),
    .ident_done(ident_done), .rc_accessory(rc_accessory), .supply_type(sup),
    .vbus_det_pin(vbus_det_pin), .id_present_pin(id_present_pin),
    .left_audio_in(left_audio_in), .right_audio_in(right_audio_in), .scl_in(scl_in),
    .sda_in(sda_in), .host_io_supply(host_io_supply), .over_voltage_ev(ev[0]),
    .over_temp_ev(ev[1]), .guard_off_ev(ev[2]), .ident_start(ident_start),
    .uart_close(uart_close),
    .usb_close(usb_close), .dp_dm_route(dp_dm_route), .vbus_route(vbus_route),
    .power_switch_on(power_switch_on), .power_save(power_save), .standby(standby),
    .sys_reset(sys_reset), .int_in(int_line), .int_out(int_out), .int_oe_n(int_oe_n),
    .charge_current_select_in(csel_line), .charge_current_select_out(csel_out),
    .charge_current_select_oe_n(csel_oe_n));
  host_line_model i_host (.int_out(int_out), .int_oe_n(int_oe_n), .csel_out(csel_out),
    .csel_oe_n(csel_oe_n), .int_line(int_line), .csel_line(csel_line));
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: v, wr: wr, rd: !wr};
    @(posedge core_clk);
    reg_req <= '0;
    #1 d = reg_rdata;
  endtask
  task automatic insertion_flag(input logic [4:0] code);
    adc_code <= code;
    adc_update <= 1'b1;
    ident_done <= 1'b1;
    @(posedge core_clk);
    adc_update <= 1'b0;
    ident_done <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  // Sync and debounce eat about ten cycles, so counts here are hold times at the pin
  task automatic press(input int n);
    @(posedge core_clk);
    key_pin <= 1'b1;
    repeat (n) @(posedge core_clk);
    key_pin <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      results();
    end
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    `CHK({int_line, csel_line, vbus_route}, 4'hd)
    foreach (rows[i])
    begin
      acc(rows[i].wr, rows[i].addr, rows[i].val);
      if (!rows[i].wr) `CHK(d, rows[i].val)
    end
    ev <= 3'h7;
    @(posedge core_clk);
    ev <= 3'h0;
    acc(0, ADDR_INT, 8'h00);
    `CHK(d, 8'he0)
    press(30);
    acc(0, ADDR_INT, 8'h00);
    `CHK(d, 8'h00)
    press(70);
    `CHK(int_line, 1'b0)
    acc(0, ADDR_INT, 8'h00);
    `CHK(d, 8'h04)
    `CHK(int_line, 1'b1)
    acc(1, ADDR_MASK, 8'h04);
    press(70);
    `CHK(int_line, 1'b1)
    acc(0, ADDR_INT, 8'h00);
    `CHK(d, 8'h04)
    acc(1, ADDR_MASK, 8'h00);
    acc(1, ADDR_TIMING, 8'h10);
    press(70);
    acc(0, ADDR_INT, 8'h00);
    `CHK(d, 8'h00)
    acc(1, ADDR_TIMING, 8'h00);
    key_pin <= 1'b1;
    repeat (200) @(posedge core_clk);
    acc(0, ADDR_INT, 8'h00);
    `CHK(d, 8'h08)
    press(1);
    acc(0, ADDR_INT, 8'h00);
    `CHK(d, 8'h10)
    acc(1, ADDR_CTRL, 8'h00);
    acc(1, ADDR_MODE, 8'h05);
    `CHK(power_save, 1'b1)
    acc(1, ADDR_MODE, 8'h01);
    `CHK(power_save, 1'b0)
    foreach (rows[i]) if (i < 4)
    begin
      insertion_flag(ID_UART_T1 + 5'(i));
      `CHK({uart_close, usb_close, power_switch_on}, i < 2 ? 3'h4 : 3'h3)
      `CHK(dp_dm_route, 3'h0)
    end
    acc(0, ADDR_INT, 8'h00);
    vbus_det_pin <= 1'b0;
    repeat (30) @(posedge core_clk);
    `CHK({int_line, standby}, 2'h1)
    acc(0, ADDR_INT, 8'h00);
    `CHK(d[FLAG_REMOVE], 1'b1)
    vbus_det_pin <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 `CHK(ident_start, 1'b1)
    sup <= 4'h1;
    insertion_flag(5'h1f);
    `CHK({power_switch_on, csel_line}, 2'h3)
    acc(1, ADDR_SW2, 8'h14);
    `CHK(csel_line, 1'b0)
    sup <= 4'h0;
    repeat (2) @(posedge core_clk);
    `CHK(power_switch_on, 1'b0)
    sup <= 4'h4;
    repeat (2) @(posedge core_clk);
    `CHK(power_switch_on, 1'b1)
    rc_accessory <= 1'b1;
    acc(1, ADDR_CTRL, 8'h20);
    repeat (105) @(posedge core_clk);
    `CHK(power_save, 1'b1)
    press(70);
    acc(0, ADDR_INT, 8'h00);
    `CHK(d, 8'h05)
    `CHK(power_save, 1'b1)
    right_audio_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    `CHK(power_save, 1'b0)
    right_audio_in <= 1'b0;
    acc(1, ADDR_MASK, 8'h55);
    acc(1, ADDR_CTRL, 8'h04);
    repeat (3) @(posedge core_clk);
    acc(0, ADDR_CTRL, 8'h00);
    `CHK(d, 8'h60)
    acc(0, ADDR_MASK, 8'h00);
    `CHK(d, 8'h00)
    acc(1, ADDR_MASK, 8'h55);
    {scl_in, sda_in} <= 2'h0;
    repeat (420) @(posedge core_clk);
    {scl_in, sda_in} <= 2'h3;
    acc(0, ADDR_MASK, 8'h00);
    `CHK(d, 8'h00)
    // Let the internal reset drop before the next write, or it is lost
    repeat (3) @(posedge core_clk);
    acc(1, ADDR_MASK, 8'h55);
    host_io_supply <= 1'b0;
    repeat (50) @(posedge core_clk);
    host_io_supply <= 1'b1;
    acc(0, ADDR_MASK, 8'h00);
    `CHK(d, 8'h55)
    host_io_supply <= 1'b0;
    repeat (3000) @(posedge core_clk);
    `CHK(sys_reset, 1'b1)
    host_io_supply <= 1'b1;
    acc(0, ADDR_MASK, 8'h00);
    `CHK(d, 8'h00)
    results();
  end
endmodule
